//--- core/mcx_pkg.sv
// Package: encodings, register offsets and field layouts for the control and wide shift group
package mcx_pkg;
	// ==========================================
	// Instruction encodings
	localparam logic [7:0] OPC_CTRL_HI = 8'h35;
	localparam logic [7:0] OPC_BACKDOOR_RD = 8'h40;
	localparam logic [4:0] OPC_CLEAR_HI5 = 5'h09;
	localparam logic [5:0] OPC_SOFTIRQ_HI6 = 6'h22;
	localparam logic [7:0] OPC_SUB_RETURN = 8'h9C;
	localparam logic [7:0] OPC_LATCH_CLEAR = 8'h9D;
	localparam logic [9:0] OPC_WLS_REG = 10'h0E5;
	localparam logic [9:0] OPC_WRS_REG = 10'h0E4;
	localparam logic [8:0] OPC_WLS_IMM = 9'h071;
	localparam logic [8:0] OPC_WRS_IMM = 9'h070;
	localparam logic [2:0] OPC_WIDE_TAIL = 3'h5;
	// ==========================================
	// Register offsets in the device bank
	localparam logic [8:0] REG_CORE0_CONTROL = 9'h101;
	localparam logic [8:0] REG_CORE1_CONTROL = 9'h102;
	localparam logic [8:0] REG_START_CONFIG_SECOND = 9'h104;
	localparam logic [8:0] REG_CORE0_STATE_FLAGS = 9'h105;
	localparam logic [8:0] REG_CORE1_STATE_FLAGS = 9'h106;
	localparam logic [8:0] REG_CORE0_INTERRUPT_STATE = 9'h10F;
	localparam logic [8:0] REG_CORE1_INTERRUPT_STATE = 9'h110;
	localparam logic [8:0] REG_CHANNEL_DIAG_ERRORS = 9'h162;
	// ==========================================
	// Clear target selector codes
	localparam logic [2:0] CLR_STATUS_ONLY = 3'h0;
	localparam logic [2:0] CLR_CONTROL_ONLY = 3'h1;
	localparam logic [2:0] CLR_STATUS_DIAG_REARM = 3'h2;
	localparam logic [2:0] CLR_ALL = 3'h3;
	localparam logic [2:0] CLR_DIAG_REARM = 3'h4;
	localparam logic [2:0] CLR_STATUS_AND_CONTROL = 3'h5;
	localparam logic [2:0] CLR_STATUS_REARM = 3'h6;
	localparam logic [2:0] CLR_REARM_ONLY = 3'h7;
	// ==========================================
	// Timing and reset values
	localparam int BACKDOOR_RD_CYCLES = 2;
	localparam int RETURN_ADDR_BITS = 10;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [9:0] ADDR_RESET = 10'h000;
	localparam logic [31:0] PAIR_RESET = 32'h0000_0000;
	// Soft request identifier sits in bits 11..10 of the interrupt state word
	localparam int IRQ_ID_LSB = 10;
	localparam int IRQ_BUSY_BIT = 12;
endpackage : mcx_pkg

//--- core/mcx_wide_shifter.sv
// Wide shifter: moves the 32-bit result pair one place per clock
`timescale 1ns/10ps
module mcx_wide_shifter
	import mcx_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Start request
	input wire logic start,
	input wire logic dir_left,
	input wire logic [CNT_W-1:0] count,
	input wire logic [WIDTH-1:0] load_value,
	// Results
	output logic busy,
	output logic done,
	output logic [WIDTH-1:0] value,
	output logic shifted_out_bit,
	output logic overflow,
	output logic precision_loss
);
	initial begin
		if (WIDTH < 2 || CNT_W < 1) begin
			$error("mcx_wide_shifter: bad width");
		end
	end

	typedef struct packed {
		logic busy;
		logic done;
		logic left;
		logic [CNT_W-1:0] remain;
		logic [WIDTH-1:0] value;
		logic sb;
		logic mo;
		logic ml;
	} mcx_shift_t;

	mcx_shift_t s_q, s_d;

	// ==========================================
	// Next state: one position per cycle
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (start) begin
			s_d.value = load_value;
			s_d.left = dir_left;
			s_d.remain = count;
			s_d.sb = 1'b0;
			s_d.mo = 1'b0;
			s_d.ml = 1'b0;
			// Zero count ends at once so done still pulses
			s_d.busy = (count != '0);
			s_d.done = (count == '0);
		end else if (s_q.busy) begin
			if (s_q.left) begin
				s_d.sb = s_q.value[WIDTH-1];
				s_d.mo = s_q.mo | s_q.value[WIDTH-1];
				s_d.value = {s_q.value[WIDTH-2:0], 1'b0};
			end else begin
				s_d.sb = s_q.value[0];
				s_d.ml = s_q.ml | s_q.value[0];
				s_d.value = {1'b0, s_q.value[WIDTH-1:1]};
			end
			s_d.remain = s_q.remain - 1'b1;
			if (s_q.remain == CNT_W'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign done = s_q.done;
	assign value = s_q.value;
	assign shifted_out_bit = s_q.sb;
	assign overflow = s_q.mo;
	assign precision_loss = s_q.ml;
endmodule : mcx_wide_shifter

//--- core/mcx_decoder.sv
// Decode and execute for control instructions and wide result shifts
`timescale 1ns/10ps
module mcx_decoder
	import mcx_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int CORE_ID = 0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Instruction issue
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [ADDR_W-1:0] current_address,
	output logic instr_ready,
	// Register operand read
	output logic [2:0] operand_select,
	input wire logic [15:0] first_register_operand,
	// Address and auxiliary registers of the core
	input wire logic [8:0] backdoor_address,
	input wire logic backdoor_address_write,
	input wire logic [ADDR_W-1:0] aux_return_address,
	// Backdoor read port to the register bank
	output logic bank_read,
	output logic [8:0] bank_address,
	input wire logic [15:0] bank_read_data,
	output logic [15:0] backdoor_data,
	output logic backdoor_data_valid,
	// Program counter control
	output logic pc_load,
	output logic [ADDR_W-1:0] pc_load_value,
	// Interrupt control
	input wire logic hw_irq_request,
	output logic hw_irq_accept,
	input wire logic irq_return,
	output logic soft_irq_request,
	output logic [1:0] soft_request_identifier,
	output logic [15:0] core_interrupt_state,
	output logic [ADDR_W-1:0] irq_return_address,
	// Register clear strobes
	output logic clear_status,
	output logic clear_control,
	output logic clear_diagnosis,
	output logic diag_rearm,
	output logic diag_irq_blocked,
	input wire logic diag_block_event,
	// Start latch
	input wire logic [15:0] start_configuration_second,
	output logic clear_start_latch,
	// Multiply result pair and condition flags
	input wire logic [15:0] product_upper_half,
	input wire logic [15:0] product_lower_half,
	output logic result_pair_load,
	output logic [15:0] new_upper_half,
	output logic [15:0] new_lower_half,
	output logic shifted_out_bit_flag,
	output logic overflow_flag,
	output logic precision_loss_flag,
	output logic operation_done_flag
);
	initial begin
		if (ADDR_W != RETURN_ADDR_BITS || CORE_ID < 0 || CORE_ID > 1) begin
			$error("mcx_decoder: unsupported parameters");
		end
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD = 3'b010,
		ST_SHIFT = 3'b100
	} mcx_state_t;

	typedef struct packed {
		mcx_state_t st;
		logic rd_spoiled;
		logic [8:0] rd_addr;
		logic [15:0] rd_data;
		logic rd_valid;
		logic soft_active;
		logic [1:0] soft_id;
		logic [ADDR_W-1:0] ret_addr;
		logic irq_pulse;
		logic blocked;
		logic clr_sr;
		logic clr_cr;
		logic clr_dg;
		logic rearm;
		logic clr_sl;
		logic pc_ld;
		logic [ADDR_W-1:0] pc_val;
		logic pair_ld;
		logic [31:0] pair;
		logic left;
		logic sb;
		logic mo;
		logic ml;
		logic od;
	} mcx_core_t;

	mcx_core_t r_q, r_d;

	// ==========================================
	// Decode helpers
	function automatic logic is_ctrl(input logic [15:0] w, input logic [7:0] lo);
		is_ctrl = (w[15:8] == OPC_CTRL_HI) && (w[7:0] == lo);
	endfunction : is_ctrl

	function automatic logic is_wide(input logic [15:0] w, input int hi_bits,
		input logic [9:0] code);
		if (hi_bits == 10) begin
			is_wide = (w[15:6] == code) && (w[2:0] == OPC_WIDE_TAIL);
		end else begin
			is_wide = (w[15:7] == code[8:0]) && (w[2:0] == OPC_WIDE_TAIL);
		end
	endfunction : is_wide

	logic d_rd, d_clr, d_soft, d_ret, d_sl, d_wlr, d_wrr, d_wli, d_wri, d_shift;
	logic [2:0] clear_target_selector;
	logic smart_on;
	logic go;

	// Instruction class decode
	always_comb begin
		d_rd = is_ctrl(instr, OPC_BACKDOOR_RD);
		d_clr = (instr[15:8] == OPC_CTRL_HI) && (instr[7:3] == OPC_CLEAR_HI5);
		d_soft = (instr[15:8] == OPC_CTRL_HI) && (instr[7:2] == OPC_SOFTIRQ_HI6);
		d_ret = is_ctrl(instr, OPC_SUB_RETURN);
		d_sl = is_ctrl(instr, OPC_LATCH_CLEAR);
		d_wlr = is_wide(instr, 10, OPC_WLS_REG);
		d_wrr = is_wide(instr, 10, OPC_WRS_REG);
		d_wli = is_wide(instr, 9, {1'b0, OPC_WLS_IMM});
		d_wri = is_wide(instr, 9, {1'b0, OPC_WRS_IMM});
		d_shift = d_wlr | d_wrr | d_wli | d_wri;
		clear_target_selector = instr[2:0];
	end

	// Smart latch enable bit for this core
	assign smart_on = start_configuration_second[CORE_ID];
	assign operand_select = instr[5:3];
	// Only one instruction of this group runs at a time
	assign instr_ready = (r_q.st == ST_IDLE);
	assign go = instr_valid && instr_ready;

	logic sh_start, sh_busy, sh_done, sh_sb, sh_mo, sh_ml;
	logic [15:0] sh_count;
	logic [31:0] sh_value;

	// Count from register operand or 4-bit immediate
	always_comb begin
		sh_start = go && d_shift;
		if (d_wli || d_wri) begin
			sh_count = {12'h000, instr[6:3]};
		end else begin
			sh_count = first_register_operand;
		end
	end

	mcx_wide_shifter #(
		.WIDTH(32),
		.CNT_W(16)
	) u_shift (
		.mclk(mclk),
		.reset(reset),
		.start(sh_start),
		.dir_left(d_wlr | d_wli),
		.count(sh_count),
		.load_value({product_upper_half, product_lower_half}),
		.busy(sh_busy),
		.done(sh_done),
		.value(sh_value),
		.shifted_out_bit(sh_sb),
		.overflow(sh_mo),
		.precision_loss(sh_ml)
	);

	// ==========================================
	// Execute
	always_comb begin
		r_d = r_q;
		r_d.rd_valid = 1'b0;
		r_d.irq_pulse = 1'b0;
		r_d.clr_sr = 1'b0;
		r_d.clr_cr = 1'b0;
		r_d.clr_dg = 1'b0;
		r_d.rearm = 1'b0;
		r_d.clr_sl = 1'b0;
		r_d.pc_ld = 1'b0;
		r_d.pair_ld = 1'b0;
		// Hardware block event wins over a re-arm in the same cycle
		if (diag_block_event) begin
			r_d.blocked = 1'b1;
		end
		// Soft interrupt guard drops when the handler returns
		if (irq_return && r_q.soft_active) begin
			r_d.soft_active = 1'b0;
		end
		case (r_q.st)
			ST_IDLE: begin
				if (go && d_rd) begin
					r_d.st = ST_RD;
					r_d.rd_addr = backdoor_address;
					r_d.rd_spoiled = 1'b0;
				end else if (go && d_soft) begin
					r_d.soft_active = 1'b1;
					r_d.soft_id = instr[1:0];
					r_d.ret_addr = current_address;
					r_d.irq_pulse = 1'b1;
				end else if (go && d_ret) begin
					r_d.pc_ld = 1'b1;
					r_d.pc_val = aux_return_address;
				end else if (go && d_clr) begin
					case (clear_target_selector)
						CLR_STATUS_ONLY: begin
							r_d.clr_sr = 1'b1;
						end
						CLR_CONTROL_ONLY: begin
							r_d.clr_cr = 1'b1;
						end
						CLR_STATUS_DIAG_REARM: begin
							r_d.clr_sr = 1'b1;
							r_d.clr_dg = 1'b1;
							r_d.rearm = 1'b1;
						end
						CLR_ALL: begin
							r_d.clr_sr = 1'b1;
							r_d.clr_cr = 1'b1;
							r_d.clr_dg = 1'b1;
							r_d.rearm = 1'b1;
						end
						CLR_DIAG_REARM: begin
							r_d.clr_dg = 1'b1;
							r_d.rearm = 1'b1;
						end
						CLR_STATUS_AND_CONTROL: begin
							r_d.clr_sr = 1'b1;
							r_d.clr_cr = 1'b1;
						end
						CLR_STATUS_REARM: begin
							r_d.clr_sr = 1'b1;
							r_d.rearm = 1'b1;
						end
						default: begin
							r_d.rearm = 1'b1;
						end
					endcase
					// Re-arm unblocks unless a block event lands now
					if (r_d.rearm && !diag_block_event) begin
						r_d.blocked = 1'b0;
					end
				end else if (go && d_sl) begin
					r_d.clr_sl = smart_on;
				end else if (sh_start) begin
					r_d.st = ST_SHIFT;
					r_d.left = d_wlr | d_wli;
					r_d.od = 1'b0;
				end
			end
			ST_RD: begin
				// Second cycle: capture bank data, spoiled if address moved
				r_d.rd_spoiled = backdoor_address_write;
				r_d.rd_data = backdoor_address_write ? WORD_RESET : bank_read_data;
				r_d.rd_valid = 1'b1;
				r_d.st = ST_IDLE;
			end
			ST_SHIFT: begin
				if (sh_done) begin
					r_d.pair = sh_value;
					r_d.pair_ld = 1'b1;
					r_d.sb = sh_sb;
					if (r_q.left) begin
						r_d.mo = sh_mo;
					end else begin
						r_d.ml = sh_ml;
					end
					r_d.od = 1'b1;
					r_d.st = ST_IDLE;
				end
			end
			default: begin
				r_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_q <= '{st: ST_IDLE, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	// ==========================================
	// Outputs
	assign bank_read = (r_q.st == ST_RD);
	assign bank_address = r_q.rd_addr;
	assign backdoor_data = r_q.rd_data;
	assign backdoor_data_valid = r_q.rd_valid;
	// Soft return resumes after the requesting line
	assign irq_return_address = r_q.ret_addr + ADDR_W'(1);
	// Hardware interrupts wait while a soft one runs
	assign hw_irq_accept = hw_irq_request && !r_q.soft_active;
	assign soft_irq_request = r_q.irq_pulse;
	assign soft_request_identifier = r_q.soft_id;
	assign core_interrupt_state = {3'h0, r_q.soft_active, r_q.soft_id, r_q.ret_addr};
	assign pc_load = r_q.pc_ld;
	assign pc_load_value = r_q.pc_val;
	assign clear_status = r_q.clr_sr;
	assign clear_control = r_q.clr_cr;
	assign clear_diagnosis = r_q.clr_dg;
	assign diag_rearm = r_q.rearm;
	assign diag_irq_blocked = r_q.blocked;
	assign clear_start_latch = r_q.clr_sl;
	assign result_pair_load = r_q.pair_ld;
	assign new_upper_half = r_q.pair[31:16];
	assign new_lower_half = r_q.pair[15:0];
	assign shifted_out_bit_flag = r_q.sb;
	assign overflow_flag = r_q.mo;
	assign precision_loss_flag = r_q.ml;
	assign operation_done_flag = r_q.od;
endmodule : mcx_decoder

//--- tb/mcx_decoder_assertions.sv
// Checker: port timing relations of the control and wide shift decoder
`timescale 1ns/10ps
module mcx_decoder_assertions
	import mcx_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int CORE_ID = 0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Instruction side
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic instr_ready,
	input wire logic [ADDR_W-1:0] current_address,
	input wire logic [ADDR_W-1:0] aux_return_address,
	input wire logic [15:0] start_configuration_second,
	// Backdoor read
	input wire logic [8:0] backdoor_address,
	input wire logic backdoor_address_write,
	input wire logic bank_read,
	input wire logic [8:0] bank_address,
	input wire logic [15:0] backdoor_data,
	input wire logic backdoor_data_valid,
	// Results
	input wire logic pc_load,
	input wire logic [ADDR_W-1:0] pc_load_value,
	input wire logic hw_irq_accept,
	input wire logic soft_irq_request,
	input wire logic [1:0] soft_request_identifier,
	input wire logic [15:0] core_interrupt_state,
	input wire logic [ADDR_W-1:0] irq_return_address,
	input wire logic diag_rearm,
	input wire logic clear_start_latch
);
	// ==========================================
	// Request sequences
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic take;
	// Taken word, shared by the read, soft, return, latch and clear request relations below
	assign take = instr_valid && instr_ready;
	sequence s_rd_req;
		take && instr == {OPC_CTRL_HI, OPC_BACKDOOR_RD};
	endsequence
	sequence s_rd_done;
		bank_read ##1 backdoor_data_valid;
	endsequence
	sequence s_soft_req;
		take && instr[15:2] == {OPC_CTRL_HI, OPC_SOFTIRQ_HI6};
	endsequence
	// ==========================================
	// Assertions
	a_read_two_cycles: assert property (s_rd_req |=> s_rd_done)
		else $error("backdoor read did not finish in two cycles");
	a_read_held_addr: assert property (s_rd_req |=> bank_address == $past(backdoor_address))
		else $error("backdoor read used wrong address");
	a_read_refused: assert property (s_rd_req |=> !instr_ready)
		else $error("new instruction accepted during read");
	a_spoiled_read: assert property (bank_read && backdoor_address_write |=> backdoor_data == 16'h0000)
		else $error("spoiled read returned data");
	a_soft_save: assert property (s_soft_req |=> soft_irq_request
		&& core_interrupt_state[9:0] == $past(current_address))
		else $error("soft interrupt did not save address");
	a_soft_ident: assert property (s_soft_req |=> soft_request_identifier == $past(instr[1:0]))
		else $error("soft interrupt identifier wrong");
	a_soft_return: assert property (core_interrupt_state[IRQ_BUSY_BIT]
		|-> irq_return_address == core_interrupt_state[9:0] + 10'h001)
		else $error("soft return address not saved plus one");
	a_no_preempt: assert property (core_interrupt_state[IRQ_BUSY_BIT] |-> !hw_irq_accept)
		else $error("soft interrupt was preempted");
	a_sub_return: assert property (take && instr == {OPC_CTRL_HI, OPC_SUB_RETURN}
		|=> pc_load && pc_load_value == $past(aux_return_address))
		else $error("return did not load auxiliary address");
	a_latch_clear: assert property (take && instr == {OPC_CTRL_HI, OPC_LATCH_CLEAR}
		|=> clear_start_latch == $past(start_configuration_second[CORE_ID]))
		else $error("latch clear ignored smart enable");
	a_rearm_select: assert property (take && instr[15:3] == {OPC_CTRL_HI, OPC_CLEAR_HI5}
		|=> diag_rearm == !($past(instr[2:0]) inside {3'h0, 3'h1, 3'h5}))
		else $error("rearm strobe wrong for selector");
endmodule : mcx_decoder_assertions

bind mcx_decoder mcx_decoder_assertions #(.ADDR_W(ADDR_W), .CORE_ID(CORE_ID)) u_chk (
	.mclk(mclk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
	.instr_ready(instr_ready), .current_address(current_address),
	.aux_return_address(aux_return_address),
	.start_configuration_second(start_configuration_second),
	.backdoor_address(backdoor_address), .backdoor_address_write(backdoor_address_write),
	.bank_read(bank_read), .bank_address(bank_address), .backdoor_data(backdoor_data),
	.backdoor_data_valid(backdoor_data_valid), .pc_load(pc_load), .pc_load_value(pc_load_value),
	.hw_irq_accept(hw_irq_accept), .soft_irq_request(soft_irq_request),
	.soft_request_identifier(soft_request_identifier),
	.core_interrupt_state(core_interrupt_state), .irq_return_address(irq_return_address),
	.diag_rearm(diag_rearm), .clear_start_latch(clear_start_latch));

//--- tb/mcx_bank_model.sv
// Partner: register bank answering backdoor reads
`timescale 1ns/10ps
module mcx_bank_model (
	// Clock
	input wire logic mclk,
	// Backdoor read port
	input wire logic bank_read,
	input wire logic [8:0] bank_address,
	output logic [15:0] bank_read_data
);
	logic [15:0] idle_q = 16'h0000;
	// Idle word changes every cycle so a stale sample never matches
	always @(posedge mclk) begin
		idle_q <= idle_q + 16'h1357;
	end
	// Each offset holds a fixed function of itself
	assign bank_read_data = bank_read ? ({7'h00, bank_address} ^ 16'hA5C3) : idle_q;
endmodule : mcx_bank_model

//--- tb/tb.sv
// Testbench: random and corner instruction streams for the decoder
`timescale 1ns/10ps
module tb;
	import mcx_pkg::*;
	// ==========================================
	// Signals
	logic mclk, reset, instr_valid, backdoor_address_write, hw_irq_request, irq_return;
	logic diag_block_event, instr_ready, bank_read, backdoor_data_valid, pc_load, hw_irq_accept;
	logic soft_irq_request, clear_status, clear_control, clear_diagnosis, diag_rearm;
	logic diag_irq_blocked, clear_start_latch, result_pair_load, shifted_out_bit_flag;
	logic overflow_flag, precision_loss_flag, operation_done_flag;
	logic [15:0] instr, first_register_operand, bank_read_data, start_configuration_second;
	logic [15:0] product_upper_half, product_lower_half, backdoor_data, core_interrupt_state;
	logic [15:0] new_upper_half, new_lower_half;
	logic [9:0] current_address, aux_return_address, pc_load_value, irq_return_address;
	logic [8:0] backdoor_address, bank_address;
	logic [2:0] operand_select;
	logic [1:0] soft_request_identifier;
	integer seed = 32'h827fae9d;
	int n_fail, n_tests, k;
	// ==========================================
	// Design and partner
	mcx_decoder u_dut (.mclk(mclk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
		.current_address(current_address), .instr_ready(instr_ready),
		.operand_select(operand_select), .first_register_operand(first_register_operand),
		.backdoor_address(backdoor_address), .backdoor_address_write(backdoor_address_write),
		.aux_return_address(aux_return_address), .bank_read(bank_read),
		.bank_address(bank_address), .bank_read_data(bank_read_data),
		.backdoor_data(backdoor_data), .backdoor_data_valid(backdoor_data_valid),
		.pc_load(pc_load), .pc_load_value(pc_load_value), .hw_irq_request(hw_irq_request),
		.hw_irq_accept(hw_irq_accept), .irq_return(irq_return),
		.soft_irq_request(soft_irq_request), .soft_request_identifier(soft_request_identifier),
		.core_interrupt_state(core_interrupt_state), .irq_return_address(irq_return_address),
		.clear_status(clear_status), .clear_control(clear_control),
		.clear_diagnosis(clear_diagnosis), .diag_rearm(diag_rearm),
		.diag_irq_blocked(diag_irq_blocked), .diag_block_event(diag_block_event),
		.start_configuration_second(start_configuration_second),
		.clear_start_latch(clear_start_latch), .product_upper_half(product_upper_half),
		.product_lower_half(product_lower_half), .result_pair_load(result_pair_load),
		.new_upper_half(new_upper_half), .new_lower_half(new_lower_half),
		.shifted_out_bit_flag(shifted_out_bit_flag), .overflow_flag(overflow_flag),
		.precision_loss_flag(precision_loss_flag), .operation_done_flag(operation_done_flag));
	mcx_bank_model u_bank (.mclk(mclk), .bank_read(bank_read), .bank_address(bank_address),
		.bank_read_data(bank_read_data));
	// ==========================================
	// Tasks
	task chk(input logic ok, input string what);
		n_tests++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : chk
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	// Word is held until the taking edge; returns just after it
	task issue(input logic [15:0] w, input logic wr);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr <= w;
		@(posedge mclk);
		instr_valid <= 1'b0;
		backdoor_address_write <= wr;
		#1;
	endtask : issue
	task do_read(input logic spoil);
		@(posedge mclk);
		backdoor_address <= 9'($random(seed));
		issue({OPC_CTRL_HI, OPC_BACKDOOR_RD}, spoil);
		chk(bank_read === 1'b1 && bank_address === backdoor_address, "read start");
		@(posedge mclk);
		backdoor_address_write <= 1'b0;
		#1;
		chk(backdoor_data_valid === 1'b1 && backdoor_data === (spoil ? 16'h0000 :
			{7'h00, backdoor_address} ^ 16'hA5C3), "read data");
	endtask : do_read
	// Selector to {status, control, diag, rearm}
	function automatic logic [3:0] clr_map(input logic [2:0] s);
		logic [3:0] t [8] = '{4'h8, 4'h4, 4'hB, 4'hF, 4'h3, 4'hC, 4'h9, 4'h1};
		return t[s];
	endfunction : clr_map
	task do_shift(input logic left, input logic imm, input int n);
		logic [31:0] p;
		logic b, ov, pl;
		logic [2:0] f;
		@(posedge mclk);
		product_upper_half <= 16'($random(seed));
		product_lower_half <= 16'($random(seed));
		first_register_operand <= 16'(n);
		#1;
		p = {product_upper_half, product_lower_half};
		{b, ov, pl} = 3'h0;
		f = 3'($random(seed));
		for (int i = 0; i < n; i++) begin
			b = left ? p[31] : p[0];
			p = left ? p << 1 : p >> 1;
			ov |= left & b;
			pl |= !left & b;
		end
		if (imm) issue({left ? OPC_WLS_IMM : OPC_WRS_IMM, 4'(n), OPC_WIDE_TAIL}, 1'b0);
		else issue({left ? OPC_WLS_REG : OPC_WRS_REG, f, OPC_WIDE_TAIL}, 1'b0);
		if (n > 0) chk(instr_ready === 1'b0, "shift not refusing");
		chk(imm || operand_select === f, "operand select");
		k = 0;
		while (operation_done_flag !== 1'b1 && k < 40) begin
			@(posedge mclk);
			#1;
			k++;
		end
		// Shifter loads at the taking edge, n shift edges, then one capture edge
		chk(k == n + 1 && result_pair_load === 1'b1, "shift length");
		chk({new_upper_half, new_lower_half} === p, "shift result");
		chk((n == 0 || shifted_out_bit_flag === b) && (left ? overflow_flag === ov :
			precision_loss_flag === pl), "shift flags");
	endtask : do_shift
	// ==========================================
	// Clock, watchdog and main sequence
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Whole run needs well under 2000 cycles
	initial begin
		#(50 * 5000);
		n_fail++;
		report_and_stop;
	end
	initial begin
		{reset, instr_valid, backdoor_address_write, hw_irq_request, irq_return} = 5'h10;
		{diag_block_event, instr, first_register_operand, current_address} = '0;
		{aux_return_address, backdoor_address, start_configuration_second} = '0;
		{product_upper_half, product_lower_half} = '0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) do_read(1'b0);
		do_read(1'b1);
		for (int id = 0; id < 4; id++) begin
			@(posedge mclk);
			current_address <= 10'($random(seed));
			hw_irq_request <= 1'b1;
			issue({OPC_CTRL_HI, OPC_SOFTIRQ_HI6, 2'(id)}, 1'b0);
			chk(soft_irq_request === 1'b1 && soft_request_identifier === 2'(id), "soft id");
			chk(core_interrupt_state[9:0] === current_address && hw_irq_accept === 1'b0
				&& irq_return_address === current_address + 10'h001, "soft save");
			irq_return <= 1'b1;
			@(posedge mclk);
			irq_return <= 1'b0;
			#1;
			chk(hw_irq_accept === 1'b1, "hw accept after return");
		end
		@(posedge mclk);
		aux_return_address <= 10'($random(seed));
		issue({OPC_CTRL_HI, OPC_SUB_RETURN}, 1'b0);
		chk(pc_load === 1'b1 && pc_load_value === aux_return_address, "return");
		for (int s = 0; s < 8; s++) begin
			@(posedge mclk);
			diag_block_event <= 1'b1;
			@(posedge mclk);
			diag_block_event <= 1'b0;
			issue({OPC_CTRL_HI, OPC_CLEAR_HI5, 3'(s)}, 1'b0);
			chk({clear_status, clear_control, clear_diagnosis, diag_rearm} === clr_map(3'(s)),
				"clear strobes");
			@(posedge mclk);
			#1;
			chk(diag_irq_blocked === ((clr_map(3'(s)) & 4'h1) == 4'h0), "rearm");
		end
		for (int b = 0; b < 2; b++) begin
			@(posedge mclk);
			start_configuration_second <= 16'(b);
			issue({OPC_CTRL_HI, OPC_LATCH_CLEAR}, 1'b0);
			chk(clear_start_latch === 1'(b), "latch clear");
		end
		issue(16'h3541, 1'b0);
		chk({soft_irq_request, pc_load, clear_status, bank_read} === 4'h0, "odd word");
		do_shift(1'b1, 1'b1, 0);
		do_shift(1'b0, 1'b1, 15);
		do_shift(1'b1, 1'b0, 20);
		do_shift(1'b0, 1'b0, 1);
		repeat (12) do_shift(1'($random(seed)), 1'($random(seed)), $unsigned($random(seed)) % 16);
		report_and_stop;
	end
endmodule : tb
